// ### rtl/power_ctrl.v
// Register interface and power command logic of a battery-backed supply controller.
// Assumes a byte-level bus front end delivering address, offset, strobes and data
// synchronous to clk_sys; clock time is kept by an internal calendar counter.
//
// What this block does
// - Answer at clock and command bus addresses
// - Clock offsets 0-6 read BCD calendar fields
// - Writes to clock fields have no effect
// - Shutdown code starts safe shutdown; host power-off only without cable power, battery stays connected
// - Command reads 0xdd during restore, then 0x00
// - Reset code restarts, calendar to 2000-01-01
// - Calibration code adjusts all A/D converters
// - Bootloader code enters loader, lights orange indicator
// - Loader exits on button, upload, 16 s idle
// - Interrupts disabled throughout bootloader
// - Run-time limit sets battery run duration
// - Expiry: safe shutdown, battery off, sleep
// - Cable power return restarts after expiry shutdown
// - Button held over 2 s restarts after expiry
// - Limit value 0xff disables the run timer
`timescale 1ns/100ps
`include "power_ctrl_regs.vh"

module power_ctrl #(
  parameter CLK_HZ = `CLK_HZ,
  parameter BOOT_IDLE_S = `BOOT_IDLE_S,
  parameter BUTTON_HOLD_MS = `BUTTON_HOLD_MS
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Register access from the bus front end
  input wire [6:0] bus_addr,
  input wire [7:0] bus_offset,
  input wire bus_write,
  input wire bus_read,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  output reg bus_ack,
  // System status
  input wire cable_power,
  input wire reset_button,
  input wire power_button,
  input wire upload_done,
  input wire loader_activity,
  input wire defaults_restoring,
  // Power control
  output reg shutdown_request,
  output reg battery_connected,
  output reg low_power_sleep,
  output reg host_power,
  output reg cpu_reset,
  output reg calibrate_start,
  output reg bootloader_active,
  output reg orange_led,
  output reg irq_enable
);

  // One-second enable; long counts are parameters so simulations can shrink them
  localparam SEC_CYCLES = CLK_HZ;
  localparam MS_CYCLES = CLK_HZ / 1000;
  // Order of scaling keeps small simulation clocks from rounding the hold time to zero
  localparam HOLD_CYCLES = (CLK_HZ >= 1000) ? MS_CYCLES * BUTTON_HOLD_MS : CLK_HZ * BUTTON_HOLD_MS / 1000;

  localparam ST_RUN = 2'd0;
  localparam ST_LOADER = 2'd1;
  localparam ST_OFF = 2'd2;

  // ==========================================================
  // Second tick divider
  reg [31:0] sec_div;
  reg sec_tick;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sec_div <= 32'h0000_0000;
      sec_tick <= 1'b0;
    end else if (sec_div >= SEC_CYCLES - 1) begin
      sec_div <= 32'h0000_0000;
      sec_tick <= 1'b1;
    end else begin
      sec_div <= sec_div + 32'h0000_0001;
      sec_tick <= 1'b0;
    end
  end

  // ==========================================================
  // Calendar counter in BCD; fields are only ever written by this counter
  reg [7:0] rtc_seconds, rtc_minutes, rtc_hours, rtc_weekday;
  reg [7:0] rtc_day_of_month, rtc_month, rtc_year;
  reg [1:0] state;
  reg clock_reload;

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function [7:0] month_days;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h02: month_days = ((y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
                 (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8))) ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
        default: month_days = 8'h31;
      endcase
    end
  endfunction

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rtc_seconds <= `RST_RTC_SECONDS;
      rtc_minutes <= `RST_RTC_MINUTES;
      rtc_hours <= `RST_RTC_HOURS;
      rtc_weekday <= `RST_RTC_WEEKDAY;
      rtc_day_of_month <= `RST_RTC_DAY_OF_MONTH;
      rtc_month <= `RST_RTC_MONTH;
      rtc_year <= `RST_RTC_YEAR;
    end else if (clock_reload) begin
      rtc_seconds <= `RST_RTC_SECONDS;
      rtc_minutes <= `RST_RTC_MINUTES;
      rtc_hours <= `RST_RTC_HOURS;
      rtc_weekday <= `RST_RTC_WEEKDAY;
      rtc_day_of_month <= `RST_RTC_DAY_OF_MONTH;
      rtc_month <= `RST_RTC_MONTH;
      rtc_year <= `RST_RTC_YEAR;
    end else if (sec_tick) begin
      // Keeps running in every state, including sleep
      if (rtc_seconds != 8'h59) begin
        rtc_seconds <= bcd_inc(rtc_seconds);
      end else begin
        rtc_seconds <= 8'h00;
        if (rtc_minutes != 8'h59) begin
          rtc_minutes <= bcd_inc(rtc_minutes);
        end else begin
          rtc_minutes <= 8'h00;
          if (rtc_hours != 8'h23) begin
            rtc_hours <= bcd_inc(rtc_hours);
          end else begin
            rtc_hours <= 8'h00;
            rtc_weekday <= (rtc_weekday == 8'h07) ? 8'h01 : bcd_inc(rtc_weekday);
            if (rtc_day_of_month != month_days(rtc_month, rtc_year)) begin
              rtc_day_of_month <= bcd_inc(rtc_day_of_month);
            end else begin
              rtc_day_of_month <= 8'h01;
              if (rtc_month != 8'h12) begin
                rtc_month <= bcd_inc(rtc_month);
              end else begin
                rtc_month <= 8'h01;
                rtc_year <= (rtc_year == 8'h99) ? 8'h00 : bcd_inc(rtc_year);
              end
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Register access
  wire hit_clock = (bus_addr == `ADDR_CLOCK);
  wire hit_cmd = (bus_addr == `ADDR_COMMAND);
  wire cmd_write = bus_write && hit_cmd && (bus_offset == `OFS_POWER_COMMAND);
  wire limit_write = bus_write && hit_cmd && (bus_offset == `OFS_BATTERY_RUNTIME_LIMIT);
  reg [7:0] power_command;
  reg [7:0] battery_runtime_limit;
  reg [7:0] next_rdata;

  always @* begin
    next_rdata = 8'h00;
    if (hit_clock) begin
      case (bus_offset)
        `OFS_RTC_SECONDS: next_rdata = rtc_seconds;
        `OFS_RTC_MINUTES: next_rdata = rtc_minutes;
        `OFS_RTC_HOURS: next_rdata = rtc_hours;
        `OFS_RTC_WEEKDAY: next_rdata = rtc_weekday;
        `OFS_RTC_DAY_OF_MONTH: next_rdata = rtc_day_of_month;
        `OFS_RTC_MONTH: next_rdata = rtc_month;
        `OFS_RTC_YEAR: next_rdata = rtc_year;
        default: next_rdata = 8'h00;
      endcase
    end else if (hit_cmd) begin
      case (bus_offset)
        `OFS_POWER_COMMAND: next_rdata = defaults_restoring ? `CMD_DEFAULTS_BUSY : power_command;
        `OFS_BATTERY_RUNTIME_LIMIT: next_rdata = battery_runtime_limit;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Writes at the clock address are acknowledged but never reach the fields
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_rdata <= 8'h00;
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (bus_read || bus_write) && (hit_clock || hit_cmd);
      if (bus_read)
        bus_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Command handling and battery run timer
  wire known_cmd = (bus_wdata == `CMD_SAFE_SHUTDOWN) || (bus_wdata == `CMD_CTRL_RESET) ||
                   (bus_wdata == `CMD_CALIBRATE) || (bus_wdata == `CMD_BOOTLOADER);
  reg [15:0] run_secs;
  reg run_active;
  reg [4:0] boot_idle;
  reg [31:0] hold_cnt;
  reg restoring_q;
  wire [31:0] run_load = `RUNTIME_BASE_S + battery_runtime_limit * `RUNTIME_STEP_S;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      power_command <= `CMD_IDLE;
      battery_runtime_limit <= `RST_RUNTIME_LIMIT;
      state <= ST_RUN;
      shutdown_request <= 1'b0;
      battery_connected <= 1'b1;
      low_power_sleep <= 1'b0;
      host_power <= 1'b1;
      cpu_reset <= 1'b0;
      calibrate_start <= 1'b0;
      bootloader_active <= 1'b0;
      orange_led <= 1'b0;
      irq_enable <= 1'b1;
      clock_reload <= 1'b0;
      run_secs <= 16'h0000;
      run_active <= 1'b0;
      boot_idle <= 5'h00;
      hold_cnt <= 32'h0000_0000;
      restoring_q <= 1'b0;
    end else begin
      cpu_reset <= 1'b0;
      calibrate_start <= 1'b0;
      clock_reload <= 1'b0;
      restoring_q <= defaults_restoring;
      if (restoring_q && !defaults_restoring)
        power_command <= `CMD_IDLE;
      if (limit_write)
        battery_runtime_limit <= bus_wdata;
      // Run-time countdown on battery; cleared while cable power is present, reloaded on the first cycle without it
      if (cable_power || battery_runtime_limit == `RUNTIME_DISABLED) begin
        run_active <= 1'b0;
        run_secs <= 16'h0000;
      end else if (!run_active) begin
        run_active <= 1'b1;
        run_secs <= run_load[15:0];
      end else if (sec_tick && run_secs != 16'h0000) begin
        run_secs <= run_secs - 16'h0001;
      end
      case (state)
        ST_RUN: begin
          if (cmd_write && known_cmd) begin
            power_command <= bus_wdata;
            case (bus_wdata)
              `CMD_SAFE_SHUTDOWN: begin
                shutdown_request <= 1'b1;
                if (!cable_power) begin
                  host_power <= 1'b0;
                  state <= ST_OFF;
                end
              end
              `CMD_CTRL_RESET: begin
                cpu_reset <= 1'b1;
                clock_reload <= 1'b1;
                power_command <= `CMD_IDLE;
              end
              `CMD_CALIBRATE: calibrate_start <= 1'b1;
              `CMD_BOOTLOADER: begin
                state <= ST_LOADER;
                bootloader_active <= 1'b1;
                orange_led <= 1'b1;
                irq_enable <= 1'b0;
                boot_idle <= 5'h00;
              end
              default: power_command <= power_command;
            endcase
          end else if (run_active && run_secs == 16'h0000) begin
            shutdown_request <= 1'b1;
            host_power <= 1'b0;
            battery_connected <= 1'b0;
            low_power_sleep <= 1'b1;
            hold_cnt <= 32'h0000_0000;
            state <= ST_OFF;
          end
          // Other codes fall through untouched
        end
        ST_LOADER: begin
          irq_enable <= 1'b0;
          if (loader_activity)
            boot_idle <= 5'h00;
          else if (sec_tick)
            boot_idle <= boot_idle + 5'h01;
          if (reset_button || upload_done || boot_idle >= BOOT_IDLE_S) begin
            state <= ST_RUN;
            bootloader_active <= 1'b0;
            orange_led <= 1'b0;
            irq_enable <= 1'b1;
            cpu_reset <= 1'b1;
            power_command <= `CMD_IDLE;
          end
        end
        ST_OFF: begin
          if (power_button)
            hold_cnt <= hold_cnt + 32'h0000_0001;
          else
            hold_cnt <= 32'h0000_0000;
          // Cable return or a long press both bring the host back
          if (cable_power || hold_cnt > HOLD_CYCLES) begin
            state <= ST_RUN;
            host_power <= 1'b1;
            battery_connected <= 1'b1;
            low_power_sleep <= 1'b0;
            shutdown_request <= 1'b0;
            power_command <= `CMD_IDLE;
            hold_cnt <= 32'h0000_0000;
            // A restart on battery must run a fresh countdown, not the expired one
            run_active <= 1'b0;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

endmodule

// ### rtl/power_ctrl_regs.vh
// Register map, command codes and timing constants of the power controller.
// Included by the controller module; holds definitions only.
`ifndef POWER_CTRL_REGS_VH
`define POWER_CTRL_REGS_VH

// Bus addresses (7-bit)
`define ADDR_CLOCK 7'h6A
`define ADDR_COMMAND 7'h6B

// Clock register offsets
`define OFS_RTC_SECONDS 8'h00
`define OFS_RTC_MINUTES 8'h01
`define OFS_RTC_HOURS 8'h02
`define OFS_RTC_WEEKDAY 8'h03
`define OFS_RTC_DAY_OF_MONTH 8'h04
`define OFS_RTC_MONTH 8'h05
`define OFS_RTC_YEAR 8'h06

// Command register offsets
`define OFS_POWER_COMMAND 8'h00
`define OFS_BATTERY_RUNTIME_LIMIT 8'h01

// Power command codes
`define CMD_SAFE_SHUTDOWN 8'hCC
`define CMD_DEFAULTS_BUSY 8'hDD
`define CMD_IDLE 8'h00
`define CMD_CTRL_RESET 8'hEE
`define CMD_CALIBRATE 8'h11
`define CMD_BOOTLOADER 8'hFF

// Reset values and run-timer disable code
`define RST_RUNTIME_LIMIT 8'h00
`define RUNTIME_DISABLED 8'hFF
`define RST_RTC_SECONDS 8'h00
`define RST_RTC_MINUTES 8'h00
`define RST_RTC_HOURS 8'h00
`define RST_RTC_WEEKDAY 8'h06
`define RST_RTC_DAY_OF_MONTH 8'h01
`define RST_RTC_MONTH 8'h01
`define RST_RTC_YEAR 8'h00

// Timing
`define CLK_HZ 100000000
`define BOOT_IDLE_S 16
`define BUTTON_HOLD_MS 2000
`define RUNTIME_BASE_S 60
`define RUNTIME_STEP_S 60

`endif

// ### test/host_model.sv
// Host side of the register bus: single-byte reads and writes.
// Assumes clk_sys is the block's clock; one strobe per access.
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire clk_sys,
  // Bus toward the block
  output reg [6:0] bus_addr,
  output reg [7:0] bus_offset,
  output reg bus_write,
  output reg bus_read,
  output reg [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire bus_ack
);
  reg acked;
  initial begin
    bus_addr = 7'h00;
    bus_offset = 8'h00;
    bus_write = 1'b0;
    bus_read = 1'b0;
    bus_wdata = 8'h00;
    acked = 1'b0;
  end
  // Lines go inverted after use so a stale value never looks valid
  task xfer(input rd, input [6:0] a, input [7:0] o, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk_sys) #1;
      bus_addr = a;
      bus_offset = o;
      bus_wdata = d;
      bus_read = rd;
      bus_write = !rd;
      @(posedge clk_sys) #1;
      bus_read = 1'b0;
      bus_write = 1'b0;
      acked = bus_ack;
      q = bus_rdata;
      bus_addr = ~a;
      bus_offset = ~o;
      bus_wdata = ~d;
    end
  endtask
endmodule

// ### test/power_ctrl_props.sv
// Port-level checks of the power controller.
// Assumes binding to power_ctrl; single clock domain.
`timescale 1ns/100ps
`include "power_ctrl_regs.vh"
module power_ctrl_props (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Bus
  input wire [6:0] bus_addr,
  input wire [7:0] bus_offset,
  input wire bus_write,
  input wire bus_read,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire bus_ack,
  // Status and control
  input wire cable_power,
  input wire reset_button,
  input wire defaults_restoring,
  input wire shutdown_request,
  input wire battery_connected,
  input wire low_power_sleep,
  input wire host_power,
  input wire cpu_reset,
  input wire calibrate_start,
  input wire bootloader_active,
  input wire orange_led,
  input wire irq_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire hit = (bus_addr == `ADDR_CLOCK) || (bus_addr == `ADDR_COMMAND);
  wire acc = bus_read || bus_write;
  // Commands only count while the system runs normally
  wire run = !shutdown_request && !bootloader_active && !low_power_sleep;
  wire cmd = run && bus_write && bus_addr == `ADDR_COMMAND && bus_offset == `OFS_POWER_COMMAND;
  ack_mine_a: assert property (acc && hit |=> bus_ack) else $error("no ack");
  ack_other_a: assert property (acc && !hit |=> !bus_ack) else $error("foreign ack");
  restore_busy_a: assert property (bus_read && bus_addr == `ADDR_COMMAND && bus_offset == `OFS_POWER_COMMAND
    && defaults_restoring |=> bus_rdata == `CMD_DEFAULTS_BUSY) else $error("restore code");
  shutdown_cmd_a: assert property (cmd && bus_wdata == `CMD_SAFE_SHUTDOWN |=> shutdown_request)
    else $error("no shutdown");
  reset_cmd_a: assert property (cmd && bus_wdata == `CMD_CTRL_RESET |=> cpu_reset ##1 !cpu_reset)
    else $error("no reset pulse");
  calib_cmd_a: assert property (cmd && bus_wdata == `CMD_CALIBRATE |=> calibrate_start ##1 !calibrate_start)
    else $error("no calibrate pulse");
  loader_entry_a: assert property (cmd && bus_wdata == `CMD_BOOTLOADER |=> bootloader_active && orange_led)
    else $error("loader not entered");
  loader_irq_a: assert property (bootloader_active |-> !irq_enable && orange_led) else $error("irq on");
  loader_exit_a: assert property (bootloader_active && reset_button |-> ##[1:4] !bootloader_active)
    else $error("loader stuck");
  sleep_state_a: assert property (low_power_sleep |-> !battery_connected) else $error("sleep on battery");
  cable_wake_a: assert property ($rose(cable_power) && low_power_sleep |-> ##[0:20] host_power)
    else $error("no wake");
  cover property (cpu_reset);
  cover property ($rose(low_power_sleep));
  cover property ($fell(bootloader_active));
endmodule
bind power_ctrl power_ctrl_props chk (.clk_sys(clk_sys), .reset(reset), .bus_addr(bus_addr),
  .bus_offset(bus_offset), .bus_write(bus_write), .bus_read(bus_read), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .cable_power(cable_power), .reset_button(reset_button),
  .defaults_restoring(defaults_restoring), .shutdown_request(shutdown_request),
  .battery_connected(battery_connected), .low_power_sleep(low_power_sleep), .host_power(host_power),
  .cpu_reset(cpu_reset), .calibrate_start(calibrate_start), .bootloader_active(bootloader_active),
  .orange_led(orange_led), .irq_enable(irq_enable));

// ### test/power_ctrl_tb.sv
// Self-checking bench of the power controller.
// Assumes host_model and the checker compile first; second tick is 100 cycles.
`timescale 1ns/100ps
`include "power_ctrl_regs.vh"
module power_ctrl_tb;
  reg clk_sys = 0;
  reg reset = 1;
  reg cable_power = 1, reset_button = 0, power_button = 0;
  reg upload_done = 0, loader_activity = 0, defaults_restoring = 0;
  wire [6:0] bus_addr;
  wire [7:0] bus_offset, bus_wdata, bus_rdata;
  wire bus_write, bus_read, bus_ack;
  wire shutdown_request, battery_connected, low_power_sleep, host_power, cpu_reset;
  wire calibrate_start, bootloader_active, orange_led, irq_enable;
  integer failures = 0;
  integer checks_done = 0;
  integer i;
  reg [7:0] q;
  reg [55:0] rv = {`RST_RTC_YEAR, `RST_RTC_MONTH, `RST_RTC_DAY_OF_MONTH, `RST_RTC_WEEKDAY,
    `RST_RTC_HOURS, `RST_RTC_MINUTES, `RST_RTC_SECONDS};
  always #5 clk_sys = ~clk_sys;
  host_model host (.clk_sys(clk_sys), .bus_addr(bus_addr), .bus_offset(bus_offset), .bus_write(bus_write),
    .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack));
  // Short second keeps the long counts within the run
  power_ctrl #(.CLK_HZ(100), .BOOT_IDLE_S(16), .BUTTON_HOLD_MS(2000)) DUT (.clk_sys(clk_sys), .reset(reset),
    .bus_addr(bus_addr), .bus_offset(bus_offset), .bus_write(bus_write), .bus_read(bus_read),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .cable_power(cable_power),
    .reset_button(reset_button), .power_button(power_button), .upload_done(upload_done),
    .loader_activity(loader_activity), .defaults_restoring(defaults_restoring),
    .shutdown_request(shutdown_request), .battery_connected(battery_connected),
    .low_power_sleep(low_power_sleep), .host_power(host_power), .cpu_reset(cpu_reset),
    .calibrate_start(calibrate_start), .bootloader_active(bootloader_active), .orange_led(orange_led),
    .irq_enable(irq_enable));
  // ==========================================
  // Helpers
  task check(input [7:0] seen, input [7:0] want, input [8*8-1:0] what);
    begin
      checks_done = checks_done + 1;
      if (seen !== want) begin
        failures = failures + 1;
        $display("mismatch at %0t: %0s got %h want %h", $time, what, seen, want);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #1;
    end
  endtask
  task do_reset;
    begin
      reset = 1;
      cyc(10);
      reset = 0;
    end
  endtask
  task wr(input [6:0] a, input [7:0] o, input [7:0] d);
    begin
      host.xfer(0, a, o, d, q);
      check(host.acked, 1, "ack");
    end
  endtask
  task rd(input [6:0] a, input [7:0] o, input [7:0] want);
    begin
      host.xfer(1, a, o, 8'h00, q);
      check(q, want, "rdata");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_clock;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        rd(`ADDR_CLOCK, i[7:0], rv[i*8+:8]);
      end
      host.xfer(1, 7'h50, 8'h00, 8'h00, q);
      check(host.acked, 0, "ack");
      wr(`ADDR_CLOCK, `OFS_RTC_MINUTES, 8'h45);
      rd(`ADDR_CLOCK, `OFS_RTC_MINUTES, `RST_RTC_MINUTES);
    end
  endtask
  task t_cmds;
    begin
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_CALIBRATE);
      check(calibrate_start, 1, "calib");
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, 8'h42);
      check(calibrate_start, 0, "nocalib");
      rd(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_CALIBRATE);
      cyc(150);
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_CTRL_RESET);
      check(cpu_reset, 1, "cpureset");
      rd(`ADDR_CLOCK, `OFS_RTC_SECONDS, `RST_RTC_SECONDS);
      rd(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_IDLE);
      // A non-zero stored code makes the clear at restore end visible
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_CALIBRATE);
      defaults_restoring = 1;
      rd(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_DEFAULTS_BUSY);
      defaults_restoring = 0;
      cyc(2);
      rd(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_IDLE);
    end
  endtask
  task t_boot;
    begin
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_BOOTLOADER);
      check({bootloader_active, orange_led, irq_enable}, 3'b110, "loader");
      cyc(1000);
      loader_activity = 1;
      cyc(1);
      loader_activity = 0;
      cyc(1000);
      check(bootloader_active, 1, "idle");
      cyc(700);
      check({bootloader_active, irq_enable}, 2'b01, "timeout");
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_BOOTLOADER);
      reset_button = 1;
      cyc(4);
      reset_button = 0;
      check(bootloader_active, 0, "button");
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_BOOTLOADER);
      upload_done = 1;
      cyc(4);
      upload_done = 0;
      check(bootloader_active, 0, "upload");
    end
  endtask
  task t_shutdown;
    begin
      do_reset;
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_SAFE_SHUTDOWN);
      check({shutdown_request, host_power}, 2'b11, "oncable");
      do_reset;
      cable_power = 0;
      wr(`ADDR_COMMAND, `OFS_POWER_COMMAND, `CMD_SAFE_SHUTDOWN);
      check({shutdown_request, host_power}, 2'b10, "onbatt");
    end
  endtask
  task t_runtime;
    begin
      do_reset;
      wr(`ADDR_COMMAND, `OFS_BATTERY_RUNTIME_LIMIT, 8'h01);
      cable_power = 0;
      cyc(3000);
      cable_power = 1;
      cyc(10);
      cable_power = 0;
      cyc(11500);
      check(battery_connected, 1, "early");
      cyc(700);
      check({battery_connected, low_power_sleep, host_power}, 3'b010, "expiry");
      power_button = 1;
      cyc(150);
      power_button = 0;
      cyc(5);
      check(host_power, 0, "short");
      power_button = 1;
      cyc(250);
      power_button = 0;
      cyc(5);
      check(host_power, 1, "button");
      do_reset;
      cable_power = 0;
      cyc(6200);
      cable_power = 1;
      cyc(20);
      check(host_power, 1, "cable");
      do_reset;
      wr(`ADDR_COMMAND, `OFS_BATTERY_RUNTIME_LIMIT, `RUNTIME_DISABLED);
      rd(`ADDR_COMMAND, `OFS_BATTERY_RUNTIME_LIMIT, `RUNTIME_DISABLED);
      cable_power = 0;
      cyc(7000);
      check(battery_connected, 1, "nolimit");
    end
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    do_reset;
    t_clock;
    t_cmds;
    t_boot;
    t_shutdown;
    t_runtime;
    tally_and_finish;
  end
  initial begin
    #600000;
    failures = failures + 1;
    tally_and_finish;
  end
endmodule
